// ---- rtl/ref_clock_request_logic.sv ----
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] request asserted through awake state, dropped on entering sleep
// [R2] request is active high: one means reference oscillator needed
// [R3] merged pin is OR of external request and internal request
// [R4] merge stays valid with core asleep or unpowered, io supply only
// [R5] pin may be handed to general purpose use when request unwanted
// [R6] sleep timing comes from low power oscillator, external or internal
// [R7] system drives external request input to a defined level always
// [R8] default main reference is 20 MHz
// [R9] auto-detect only within 50 ppm reference, 250 ppm oscillator error
// [R10] synthesizer accepts 12 to 52 MHz, trim step 2 ppm
// [R11] trim corrects initial tolerance of plus or minus 50 ppm
// [R12] system gives stable external low power clock during power-on reset
// [R13] OR merge purely combinational, no clocked stage
module ref_clock_request_logic
(
   input  wire  logic                        clock,
   input  wire  logic                        arst_n,
   input  wire  logic                        sleep_req,
   input  wire  logic                        wake_req,
   input  wire  logic                        merge_enable,
   input  wire  logic                        ext_clk_req_in,
   input  wire  logic                        clk_req_feature_en,
   input  wire  logic                        gpio_alt_out,
   input  wire  logic                        gpio_alt_oe_n,
   input  wire  logic                        ext_low_power_oscillator_sel,
   input  wire  logic                        nvram_ref_valid,
   input  wire  logic [15:0]                 nvram_ref_khz,
   input  wire  logic                        detect_done,
   input  wire  logic [4:0]                  detect_index,
   input  wire  logic [8:0]                  detect_ref_ppm,
   input  wire  logic [8:0]                  detect_lpo_ppm,
   input  wire  logic                        trim_load,
   input  wire  logic signed [6:0]           trim_value,
   output logic                              clk_req_out,
   output logic                              clk_req_oe_n,
   output logic                              internal_req,
   output logic                              sleep_timing_sel,
   output logic                              sleep_use_ext_osc,
   output ref_clock_pkg::ref_config_t        ref_config
);
   import ref_clock_pkg::*;

   power_state_t state_ff;
   power_state_t nxt_state;
   ref_config_t  cfg_ff;
   ref_config_t  nxt_cfg;

   // power state: sleep and wake requests; wake wins when both arrive
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         PWR_AWAKE: if (sleep_req && !wake_req) nxt_state = PWR_SLEEP;
         PWR_SLEEP: if (wake_req) nxt_state = PWR_AWAKE;
         default:   nxt_state = PWR_AWAKE;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         state_ff <= PWR_AWAKE;
      else
         state_ff <= nxt_state;
   end

   // [R1] request follows state
   // [R2] high means oscillator needed
   assign internal_req = (state_ff == PWR_AWAKE);

   // [R6] sleep timing source select
   assign sleep_timing_sel  = (state_ff == PWR_SLEEP);
   assign sleep_use_ext_osc = ext_low_power_oscillator_sel;

   // the merge sits beside the pad, so it must not wait on any core clock;
   // a floating external input would leak, so the system must tie it off
   // [R3] OR merge of requests
   // [R13] no clocked stage
   // [R7] relies on driven input
   wire merged_req = ext_clk_req_in | internal_req;
   wire own_req    = merge_enable ? merged_req : internal_req;

   // [R4] pad level, valid with core off
   // [R5] pin falls back to general purpose use
   assign clk_req_out  = clk_req_feature_en ? own_req : gpio_alt_out;
   assign clk_req_oe_n = clk_req_feature_en ? 1'b0 : gpio_alt_oe_n;

   // reference selection decode
   wire        idx_ok    = (detect_index < 5'(NUM_STD_FREQS));
   // [R9] detection error limits
   wire        detect_ok = detect_done && idx_ok
                           && (detect_ref_ppm < 9'(REF_DETECT_PPM))
                           && (detect_lpo_ppm < 9'(LPO_DETECT_PPM));
   // [R10] accepted reference range
   wire        nv_ok     = nvram_ref_valid
                           && (nvram_ref_khz >= 16'(REF_MIN_KHZ))
                           && (nvram_ref_khz <= 16'(REF_MAX_KHZ));
   // signed limit, so a negative trim is not compared as a large unsigned value
   wire signed [6:0] trim_lim = 7'(TRIM_MAX_STEPS);
   // [R11] trim limited to +-50 ppm
   wire        trim_ok   = (trim_value <= trim_lim)
                           && (trim_value >= -trim_lim);

   // nvram beats detection; detection only counts within the error limits
   always_comb
   begin
      nxt_cfg = cfg_ff;
      if (nv_ok)
      begin
         nxt_cfg.ref_khz  = nvram_ref_khz;
         nxt_cfg.detected = 1'b0;
      end
      else if (detect_ok)
      begin
         nxt_cfg.ref_khz  = STD_FREQ_KHZ[detect_index];
         nxt_cfg.detected = 1'b1;
      end
      if (trim_load && trim_ok)
         nxt_cfg.trim_steps = trim_value;
   end

   // [R8] 20 MHz after reset
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         cfg_ff <= '{ref_khz: 16'(REF_DEFAULT_KHZ), detected: 1'b0, trim_steps: TRIM_RESET};
      else
         cfg_ff <= nxt_cfg;
   end

   assign ref_config = cfg_ff;

   // assertions
   a_req_awake: assert property (@(posedge clock) disable iff (!arst_n) // [R1]
      (state_ff == PWR_AWAKE) |-> internal_req)
      else $error("request low while awake");

   a_req_sleep_drop: assert property (@(posedge clock) disable iff (!arst_n) // [R1]
      (state_ff == PWR_AWAKE && sleep_req && !wake_req) |=> !internal_req)
      else $error("request not dropped on sleep");

   a_merge_or: assert property (@(posedge clock) disable iff (!arst_n) // [R3]
      (clk_req_feature_en && merge_enable)
         |-> (clk_req_out == (ext_clk_req_in | internal_req)))
      else $error("merged request is not an OR");

   a_merge_comb: assert property (@(posedge clock) disable iff (!arst_n) // [R13]
      (clk_req_feature_en && merge_enable && ext_clk_req_in) |-> clk_req_out)
      else $error("external request not passed at once");

   a_gpio_reuse: assert property (@(posedge clock) disable iff (!arst_n) // [R5]
      !clk_req_feature_en |-> (clk_req_out == gpio_alt_out
                              && clk_req_oe_n == gpio_alt_oe_n))
      else $error("pin not released to alternate use");

   a_sleep_timing: assert property (@(posedge clock) disable iff (!arst_n) // [R6]
      sleep_timing_sel == !internal_req)
      else $error("sleep timing select mismatch");

   a_detect_limit: assert property (@(posedge clock) disable iff (!arst_n) // [R9]
      (!nv_ok && detect_done && detect_lpo_ppm >= 9'(LPO_DETECT_PPM))
         |=> $stable(ref_config.ref_khz))
      else $error("detection accepted outside limits");

   a_ref_range: assert property (@(posedge clock) disable iff (!arst_n) // [R10]
      (ref_config.ref_khz >= 16'(REF_MIN_KHZ)) && (ref_config.ref_khz <= 16'(REF_MAX_KHZ)))
      else $error("reference outside accepted range");

   a_trim_range: assert property (@(posedge clock) disable iff (!arst_n) // [R11]
      (ref_config.trim_steps <= trim_lim)
         && (ref_config.trim_steps >= -trim_lim))
      else $error("trim outside range");

   // steps of a power transition, shared by the transition checks
   sequence s_sleep_taken;
      (state_ff == PWR_AWAKE) && sleep_req && !wake_req;
   endsequence

   sequence s_wake_taken;
      (state_ff == PWR_SLEEP) && wake_req;
   endsequence

   sequence s_stay_asleep;
      (state_ff == PWR_SLEEP) && !wake_req;
   endsequence

   // a wake must raise the request on the very next edge, or the oscillator
   // would start late and the first awake cycles would run on a cold reference
   a_req_wake_rise: assert property (@(posedge clock) disable iff (!arst_n) // [R1]
      s_wake_taken |=> internal_req)
      else $error("request not raised on wake");

   a_req_sleep_hold: assert property (@(posedge clock) disable iff (!arst_n) // [R1]
      s_stay_asleep |=> !internal_req)
      else $error("request raised while still asleep");

   a_sleep_timing_set: assert property (@(posedge clock) disable iff (!arst_n) // [R6]
      s_sleep_taken |=> sleep_timing_sel)
      else $error("sleep timing not selected after sleep");

   a_ext_osc_pass: assert property (@(posedge clock) disable iff (!arst_n) // [R6]
      sleep_use_ext_osc == ext_low_power_oscillator_sel)
      else $error("oscillator source select not passed");

   a_pin_driven: assert property (@(posedge clock) disable iff (!arst_n) // [R4]
      clk_req_feature_en |-> !clk_req_oe_n)
      else $error("request pin not driven");

   // nvram wins over a detection result presented in the same cycle
   a_nv_priority: assert property (@(posedge clock) disable iff (!arst_n) // [R10]
      nv_ok |=> (ref_config.ref_khz == $past(nvram_ref_khz) && !ref_config.detected))
      else $error("nvram reference not taken");

   a_detect_take: assert property (@(posedge clock) disable iff (!arst_n) // [R9]
      (!nv_ok && detect_ok) |=> ref_config.detected)
      else $error("valid detection not taken");

   a_trim_refused: assert property (@(posedge clock) disable iff (!arst_n) // [R11]
      (trim_load && !trim_ok) |=> $stable(ref_config.trim_steps))
      else $error("out of range trim loaded");

endmodule : ref_clock_request_logic

`default_nettype wire

// ---- include/ref_clock_pkg.sv ----
package ref_clock_pkg;

   // main reference figures, in kHz unless noted
   localparam int unsigned REF_DEFAULT_KHZ   = 20000;
   localparam int unsigned REF_MIN_KHZ       = 12000;
   localparam int unsigned REF_MAX_KHZ       = 52000;
   localparam int unsigned TRIM_STEP_PPM     = 2;
   localparam int unsigned TRIM_STEP_HZ      = 80;
   localparam int          TRIM_RANGE_PPM    = 50;
   localparam int unsigned REF_DETECT_PPM    = 50;
   localparam int unsigned LPO_DETECT_PPM    = 250;
   localparam int unsigned LPO_NOMINAL_HZ    = 32768;
   localparam int unsigned NUM_STD_FREQS     = 17;

   // trim word in steps: +-50 ppm / 2 ppm = +-25 steps
   localparam int          TRIM_MAX_STEPS    = TRIM_RANGE_PPM / int'(TRIM_STEP_PPM);
   localparam logic [6:0]  TRIM_RESET        = 7'h00;

   // standard reference frequencies, in kHz
   localparam logic [15:0] STD_FREQ_KHZ [NUM_STD_FREQS] = '{
      16'h2EE0, 16'h32C8, 16'h3840, 16'h3C00, 16'h3F48, 16'h41A0, 16'h4650,
      16'h4B00, 16'h4BF0, 16'h4CE0, 16'h4D58, 16'h4E20, 16'h5DC0, 16'h6590,
      16'h8340, 16'h9218, 16'h9600};

   typedef enum logic {
      PWR_AWAKE,
      PWR_SLEEP
   } power_state_t;

   // result of reference selection
   typedef struct packed {
      logic [15:0] ref_khz;
      logic        detected;
      logic signed [6:0] trim_steps;
   } ref_config_t;

endpackage : ref_clock_pkg

// ---- testbench/sys_req_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// system requester and oscillator seen from the request pin
module sys_req_model
(
   input  wire logic want,
   input  wire logic clk_req_out,
   output var  logic ext_clk_req_in,
   output var  logic osc_on
);
   // never floats, an unknown want reads as 0
   always_comb ext_clk_req_in = (want === 1'b1);
   // oscillator runs only while the pin asks for it
   always_comb osc_on = (clk_req_out === 1'b1);
endmodule : sys_req_model
`default_nettype wire

// ---- testbench/tb_ref_clock_request_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ref_clock_request_logic;
   import ref_clock_pkg::*;
   logic clock, arst_n, sleep_req, wake_req, merge_enable, want, feat, g_out, g_oe_n, ext_sel;
   logic nv_v, dd, tl;
   logic [15:0] nv_k;
   logic [4:0] ix;
   logic [8:0] rp, lp;
   logic signed [6:0] tv;
   wire logic ext_in, r_out, r_oe_n, i_req, s_sel, u_ext, osc_on;
   ref_config_t cfg;
   int n_errors, n_tests, seed, m_khz, m_det, m_trim, m_awake, i;
   // standard references in kHz, written out independently of the design table
   int std_khz [17] = '{12000, 13000, 14400, 15360, 16200, 16800, 18000, 19200, 19440,
      19680, 19800, 20000, 24000, 26000, 33600, 37400, 38400};
   ref_clock_request_logic DUT (.clock(clock), .arst_n(arst_n), .sleep_req(sleep_req),
      .wake_req(wake_req), .merge_enable(merge_enable), .ext_clk_req_in(ext_in),
      .clk_req_feature_en(feat), .gpio_alt_out(g_out), .gpio_alt_oe_n(g_oe_n),
      .ext_low_power_oscillator_sel(ext_sel), .nvram_ref_valid(nv_v), .nvram_ref_khz(nv_k),
      .detect_done(dd), .detect_index(ix), .detect_ref_ppm(rp), .detect_lpo_ppm(lp),
      .trim_load(tl), .trim_value(tv), .clk_req_out(r_out), .clk_req_oe_n(r_oe_n),
      .internal_req(i_req), .sleep_timing_sel(s_sel), .sleep_use_ext_osc(u_ext),
      .ref_config(cfg));
   sys_req_model partner (.want(want), .clk_req_out(r_out), .ext_clk_req_in(ext_in),
      .osc_on(osc_on));
   // free running clock, 10 ns period
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s exp %b got %b", nm, e, g);
      end
   endtask : chk_bit
   task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk_val
   // pin and state outputs against the model
   task automatic pins();
      chk_bit("pin", feat ? (m_awake[0] | (merge_enable & want)) : g_out, r_out);
      chk_bit("oe_n", feat ? 1'b0 : g_oe_n, r_oe_n);
      chk_bit("osc_on", feat ? (m_awake[0] | (merge_enable & want)) : g_out, osc_on);
      chk_bit("int_req", m_awake[0], i_req);
      chk_bit("sleep_sel", !m_awake[0], s_sel);
      chk_bit("ext_osc", ext_sel, u_ext);
      chk_val("khz", m_khz[15:0], cfg.ref_khz);
      chk_val("trim", {9'h000, m_trim[6:0]}, {9'h000, cfg.trim_steps});
   endtask : pins
   // one configuration request, applied for one cycle
   task automatic cfg_op(input logic v, input logic [15:0] k, input logic d, input logic [4:0] x,
      input logic [8:0] r, input logic [8:0] l, input logic t, input logic signed [6:0] tr);
      {nv_v, nv_k, dd, ix, rp, lp, tl, tv} = {v, k, d, x, r, l, t, tr};
      @(negedge clock);
      {nv_v, dd, tl} = 3'h0;
      if (v && k >= REF_MIN_KHZ && k <= REF_MAX_KHZ)
      begin
         m_khz = k;
         m_det = 0;
      end
      else if (d && x < NUM_STD_FREQS && r < REF_DETECT_PPM && l < LPO_DETECT_PPM)
      begin
         m_khz = std_khz[x];
         m_det = 1;
      end
      if (t && tr >= -TRIM_MAX_STEPS && tr <= TRIM_MAX_STEPS)
         m_trim = tr;
      pins();
      chk_bit("detected", m_det[0], cfg.detected);
   endtask : cfg_op
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   initial
   begin
      #100000;
      n_errors++;
      wrap_up();
   end
   initial
   begin
      // low power source choice held steady through reset
      {arst_n, sleep_req, wake_req, merge_enable, want, g_out, g_oe_n, ext_sel} = 8'h00;
      {nv_v, nv_k, dd, ix, rp, lp, tl, tv} = '0;
      {feat, seed, m_khz, m_det, m_trim, m_awake} = {1'b1, 32'd54, 32'd20000, 96'd1};
      repeat (16) @(negedge clock);
      arst_n = 1'b1;
      pins();
      chk_bit("detected", 1'b0, cfg.detected);
      // random sleep and wake traffic with merge and gpio hand-over
      for (i = 0; i < 40; i++)
      begin
         {want, merge_enable, ext_sel, sleep_req, wake_req, g_out, g_oe_n} = 7'($random(seed));
         feat = (i % 7 != 3);
         #1 chk_bit("comb_pin", feat ? (m_awake[0] | (merge_enable & want)) : g_out, r_out);
         @(negedge clock);
         if (wake_req)
            m_awake = 1;
         else if (sleep_req)
            m_awake = 0;
         {sleep_req, wake_req} = 2'h0;
         pins();
      end
      $display("test power and pin done");
      // detection limits and trim, then nvram range and priority
      cfg_op(0, 0, 1, 5'h10, 9'h031, 9'h0F9, 0, 0);
      cfg_op(0, 0, 1, 5'h00, 9'h032, 9'h000, 0, 0);
      cfg_op(0, 0, 1, 5'h03, 9'h000, 9'h0FA, 0, 0);
      cfg_op(0, 0, 1, 5'h11, 9'h000, 9'h000, 0, 0);
      cfg_op(0, 0, 1, 5'h0B, 9'h000, 9'h000, 1, 7'sh19);
      cfg_op(0, 0, 0, 0, 0, 0, 1, 7'sh1A);
      cfg_op(0, 0, 0, 0, 0, 0, 1, -7'sh19);
      cfg_op(0, 0, 0, 0, 0, 0, 1, -7'sh1A);
      cfg_op(1, 16'h2EDF, 0, 0, 0, 0, 0, 0);
      cfg_op(1, 16'h2EE0, 1, 5'h10, 0, 0, 0, 0);
      cfg_op(1, 16'hCB21, 0, 0, 0, 0, 0, 0);
      cfg_op(1, 16'hCB20, 0, 0, 0, 0, 0, 0);
      $display("test reference config done");
      // every standard index, with random errors inside both limits
      for (i = 0; i < 17; i++)
         cfg_op(0, 0, 1, 5'(i), 9'($random(seed)) % 9'd50, 9'($random(seed)) % 9'd250, 0, 0);
      $display("test detection sweep done");
      // sleep, then a second reset must restore awake and the default reference
      sleep_req = 1'b1;
      @(negedge clock);
      sleep_req = 1'b0;
      m_awake = 0;
      pins();
      arst_n = 1'b0;
      repeat (2) @(negedge clock);
      arst_n = 1'b1;
      {m_khz, m_det, m_trim, m_awake} = {32'd20000, 32'd0, 32'd0, 32'd1};
      pins();
      chk_bit("detected", 1'b0, cfg.detected);
      $display("test second reset done");
      wrap_up();
   end
endmodule : tb_ref_clock_request_logic
`default_nettype wire
